/* pkg/pulse_switch_defs.svh */
// Purpose: Timing and width constants for the pulse-count switch control
// Assumes: 10 MHz system clock
// Notes:   Counts are derived from times in microseconds
`ifndef PULSE_SWITCH_DEFS_SVH
`define PULSE_SWITCH_DEFS_SVH
`define CLK_MHZ            10
`define LATCH_HOLD_US      50
`define DISABLE_US         500
`define LATCH_HOLD_CYCLES  (`LATCH_HOLD_US * `CLK_MHZ)
`define DISABLE_CYCLES     (`DISABLE_US * `CLK_MHZ)
`define TIMER_W            13
`define SYNC_STAGES        2
`endif

/* pkg/pulse_switch_pkg.sv */
// Purpose: Types for the pulse-count switch control
// Assumes: Imported by the top module only
// Notes:   Six outputs maximum
package pulse_switch_pkg;
  typedef logic [5:0] count_t;
  typedef logic [5:0] pattern_t;
  typedef enum logic [1:0] {
    st_disabled,
    st_counting,
    st_latched
  } ctrl_state_t;
endpackage

/* pkg/pin_sync_if.sv */
// Purpose: Carries the synchronised control pin and its rising edge
// Assumes: One clock domain
// Notes:   Driven by the sync module, read by the top
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

/* rtl/pin_edge_sync.sv */
// Purpose: Two-flop synchroniser and edge detector for the control pin
// Assumes: Pin is asynchronous to clk_i
// Notes:   Edge logic looks only at the second and third stage
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync (
  input  wire logic   clk_i,
  input  wire logic   arst_n_i,
  input  wire logic   pin_i,
  pin_sync_if.src     sync
);
  logic meta;
  logic stable;
  logic prev;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      prev   <= 1'b0;
    end else begin
      meta   <= pin_i;
      stable <= meta;
      prev   <= stable;
    end
  end

  assign sync.level = stable;
  assign sync.rise  = stable & ~prev;
  assign sync.fall  = ~stable & prev;
endmodule
`default_nettype wire

/* rtl/pulse_count_switch_control.sv */
// Purpose: Single-wire pulse-count control of five or six push/pull switches
// Assumes: 10 MHz clock; control pin pulses no faster than 1 MHz
// Notes:   Drive and pull-down enables are separate so off means driven low
// Function
// - Only rising edges on the control pin select the output configuration.
// - The count is applied only after the pin has stayed high for the latch hold time.
// - The count decodes into 32 states for five outputs or 64 states for six outputs.
// - Pulses up to 1 MHz are counted and no intermediate count reaches the outputs.
// - The first rising edge after disable enables the device with every output on.
// - A low level lasting 500 us disables the device, turns all outputs off and clears the count.
// - Output k is off exactly when bit k-1 of the count minus one is set.
// - Every off output is actively pulled to ground, also while disabled.
`timescale 1ns/1ps
`default_nettype none
`include "pulse_switch_defs.svh"
module pulse_count_switch_control
  import pulse_switch_pkg::*;
#(
  parameter bit                  SIX_OUTPUTS    = 1'b1,
  parameter logic [`TIMER_W-1:0] LATCH_CYCLES   = `TIMER_W'(`LATCH_HOLD_CYCLES),
  parameter logic [`TIMER_W-1:0] DISABLE_CYCLES = `TIMER_W'(`DISABLE_CYCLES)
) (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       ctrl_pin_i,
  output logic            enabled_o,
  output logic [5:0]      switch_drive_high_o,
  output logic [5:0]      switch_pull_low_o
);
  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  pin_sync_if pin ();

  pin_edge_sync u_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .pin_i    (ctrl_pin_i),
    .sync     (pin)
  );

  // ****************************************************************
  // State and counters
  // ****************************************************************
  ctrl_state_t         state;
  count_t              pending;
  pattern_t            off_mask;
  logic [`TIMER_W-1:0] high_timer;
  logic [`TIMER_W-1:0] low_timer;
  logic                latch_due;
  logic                disable_due;
  count_t              wrap_mask;

  // Five-output variant keeps only five count bits so 33 edges wrap to 1
  assign wrap_mask   = SIX_OUTPUTS ? 6'h3f : 6'h1f;
  assign latch_due   = pin.level && (high_timer == LATCH_CYCLES - `TIMER_W'(1));
  assign disable_due = !pin.level && (low_timer == DISABLE_CYCLES - `TIMER_W'(1));

  // Timers restart on each edge, so a 1 MHz burst never reaches the latch time
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      high_timer <= '0;
    end else if (!pin.level || pin.rise) begin
      high_timer <= '0;
    end else if (high_timer != LATCH_CYCLES) begin
      high_timer <= high_timer + `TIMER_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      low_timer <= '0;
    end else if (pin.level) begin
      low_timer <= '0;
    end else if (low_timer != DISABLE_CYCLES) begin
      low_timer <= low_timer + `TIMER_W'(1);
    end
  end

  // Pending holds count minus one, so the first edge gives zero: all on
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state   <= st_disabled;
      pending <= '0;
    end else begin
      case (state)
        st_disabled: begin
          if (pin.rise) begin
            state   <= st_latched;
            pending <= '0;
          end
        end
        st_counting, st_latched: begin
          if (disable_due) begin
            state   <= st_disabled;
            pending <= '0;
          end else if (pin.rise) begin
            state   <= st_counting;
            pending <= (pending + count_t'(1)) & wrap_mask;
          end else if (latch_due) begin
            state <= st_latched;
          end
        end
        default: begin
          state   <= st_disabled;
          pending <= '0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Output pattern
  // ****************************************************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      off_mask <= '0;
    end else if (state == st_disabled && pin.rise) begin
      off_mask <= '0;
    end else if (state == st_counting && latch_due && !pin.rise) begin
      off_mask <= pending;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      enabled_o           <= 1'b0;
      switch_drive_high_o <= '0;
      switch_pull_low_o   <= 6'h3f;
    end else begin
      enabled_o           <= (state != st_disabled);
      // Sixth output is held low on the five-output variant
      switch_drive_high_o <= (state != st_disabled) ? (~off_mask & wrap_mask) : 6'h00;
      switch_pull_low_o   <= (state != st_disabled) ? ~(~off_mask & wrap_mask) : 6'h3f;
    end
  end
endmodule
`default_nettype wire

/* testbench/pcs_asserts.sv */
// Purpose: Port checks for the switch control
// Assumes: Host pulses last 5 clocks or more
// Notes:   Counters see the raw pin; margins cover sync lag
`timescale 1ns/1ps
`default_nettype none
module pcs_asserts #(
  parameter int LATCH_CYCLES   = 500,
  parameter int DISABLE_CYCLES = 5000
) (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       ctrl_pin_i,
  input  wire logic       enabled_o,
  input  wire logic [5:0] switch_drive_high_o,
  input  wire logic [5:0] switch_pull_low_o
);
  logic [15:0] hi;
  logic [15:0] lo;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hi <= '0;
      lo <= '0;
    end else begin
      hi <= ctrl_pin_i ? hi + 16'h1 : '0;
      lo <= ctrl_pin_i ? '0 : lo + 16'h1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  a_pull_complement: assert property (switch_pull_low_o == ~switch_drive_high_o) else $error("pull");
  a_off_disabled: assert property (!enabled_o && $past(!enabled_o) |-> switch_drive_high_o == 6'h00) else $error("off");
  a_first_on: assert property (
    $rose(ctrl_pin_i) && !enabled_o |-> ##[1:8] enabled_o && switch_drive_high_o == 6'h3f)
    else $error("first");
  a_latch_wait: assert property (
    ctrl_pin_i && $past(enabled_o, 2) && $changed(switch_drive_high_o) |-> hi >= LATCH_CYCLES)
    else $error("latch");
  a_no_early_off: assert property ($fell(enabled_o) |-> lo >= DISABLE_CYCLES) else $error("early");
  a_late_off: assert property (lo >= DISABLE_CYCLES + 6 |-> !enabled_o) else $error("late");
  a_low_stable: assert property (lo >= 6 && lo < DISABLE_CYCLES |-> $stable(switch_drive_high_o)) else $error("low");
  a_count_hidden: assert property (
    hi >= 5 && hi < LATCH_CYCLES && $past(enabled_o, 2) |-> $stable(switch_drive_high_o))
    else $error("mid");
  c_on: cover property ($rose(enabled_o));
  c_off: cover property ($fell(enabled_o));
  c_latch: cover property (enabled_o && $changed(switch_drive_high_o));
endmodule
bind pulse_count_switch_control pcs_asserts #(.LATCH_CYCLES(LATCH_CYCLES), .DISABLE_CYCLES(DISABLE_CYCLES)) chk (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .ctrl_pin_i(ctrl_pin_i), .enabled_o(enabled_o),
  .switch_drive_high_o(switch_drive_high_o), .switch_pull_low_o(switch_pull_low_o));
`default_nettype wire

/* testbench/pcs_host.sv */
// Purpose: Host pin model
// Assumes: Push/pull pin, changed at falling clock edges
// Notes:   Burst leaves the pin high
`timescale 1ns/1ps
`default_nettype none
module pcs_host (
  input  wire logic clk_i,
  output var  logic ctrl_pin_o
);
  initial ctrl_pin_o = 1'b0;
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Five clocks per phase, the 1 MHz ceiling
  task automatic burst(input int n);
    for (int i = 0; i < n; i++) begin
      if (i > 0) begin
        ctrl_pin_o = 1'b0;
        wait_clk(5);
      end
      ctrl_pin_o = 1'b1;
      wait_clk(5);
    end
  endtask
  task automatic low(input int n);
    ctrl_pin_o = 1'b0;
    wait_clk(n);
  endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Purpose: Self-checking bench
// Assumes: Six outputs
// Notes:   Short latch and disable counts
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int LAT = 8;
  localparam int DIS = 40;
  logic       clk_i = 1'b0;
  logic       arst_n_i = 1'b0;
  logic       pin;
  logic       en;
  logic [5:0] drv;
  logic [5:0] pull;
  int         err_total = 0;
  int         num_checks = 0;
  always #50 clk_i = ~clk_i;
  pcs_host host (.clk_i(clk_i), .ctrl_pin_o(pin));
  pulse_count_switch_control #(.LATCH_CYCLES(13'(LAT)), .DISABLE_CYCLES(13'(DIS))) DUT (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .ctrl_pin_i(pin), .enabled_o(en), .switch_drive_high_o(drv), .switch_pull_low_o(pull));
  task automatic check(input logic [6:0] exp);
    num_checks++;
    if ({en, drv} !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, {en, drv}, exp);
    end
  endtask
  task automatic off();
    host.low(DIS + 8);
    check(7'h00);
    if (pull !== 6'h3f) begin
      err_total++;
      $display("BAD %0t pull %h", $time, pull);
    end
  endtask
  task automatic t_count(input int n);
    host.burst(n);
    host.wait_clk(2);
    check(7'h7f);
    host.wait_clk(LAT + 6);
    check({1'b1, ~6'(n - 1)});
    off();
    $display("count %0d done", n);
  endtask
  task automatic t_step();
    host.burst(2);
    host.wait_clk(LAT + 8);
    host.low(DIS - 10);
    check(7'h7e);
    host.burst(1);
    host.wait_clk(LAT + 8);
    check(7'h7d);
    off();
    $display("step done");
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk_i);
    arst_n_i = 1'b1;
    t_count(1);
    t_count(2);
    t_count(33);
    t_count(64);
    t_count(65);
    t_step();
    results();
  end
  // Roughly ten times the expected run
  initial begin
    #2000000;
    err_total++;
    results();
  end
endmodule
`default_nettype wire
